// File: hw/rmdc_defs.vh
// rmdc_defs.vh: register offset, field positions and reset values of the
// reader-mode demodulator configuration block; definitions only.
`ifndef RMDC_DEFS_VH
`define RMDC_DEFS_VH

`define RMDC_CFG_OFFSET     12'h01C
`define RMDC_IQ_MSB         23
`define RMDC_IQ_LSB         21
`define RMDC_TESTF_BIT      20
`define RMDC_RESYNC_BIT     19
`define RMDC_CCLR_BIT       18
`define RMDC_VFOFF_BIT      17
`define RMDC_DBMIN_BIT      16
`define RMDC_SCTH_MSB       15
`define RMDC_SCTH_LSB       12
`define RMDC_PSTH_MSB       11
`define RMDC_PSTH_LSB       8
`define RMDC_SEVAL_BIT      7
`define RMDC_COLL_MSB       6
`define RMDC_COLL_LSB       5

`define RMDC_IQ_BOTH        3'h0
`define RMDC_IQ_ONLY_I      3'h1
`define RMDC_IQ_ONLY_Q      3'h2
`define RMDC_IQ_STRONG      3'h4
`define RMDC_IQ_FIRST       3'h5

`define RMDC_COLL_P12       2'h0
`define RMDC_COLL_P25       2'h1
`define RMDC_COLL_P50       2'h2
`define RMDC_COLL_OFF       2'h3

`define RMDC_RST_IQ         3'h0
`define RMDC_RST_TESTF      1'h0
`define RMDC_RST_RESYNC     1'h1
`define RMDC_RST_CCLR       1'h1
`define RMDC_RST_VFOFF      1'h0
`define RMDC_RST_DBMIN      1'h0
`define RMDC_RST_TH         4'h0
`define RMDC_RST_COLL       2'h0

`endif

// File: hw/rmdc_reader_demod_config.v
// rmdc_reader_demod_config.v: configuration register and control glue of
// the reader-mode receive signal processor, reached over APB.
// assumes demodulator strobes and samples come from logic on clk.
//
// Contract
// - iq field 23:21 picks both, I, Q, stronger or first channel.
// - bit 19 set: resync during start of frame on equal correlation.
// - bit 18 set: correlator cleared whenever the receiver resets.
// - bpsk: bit 17 clear combines 0110 with 1110/0111; set uses 0110.
// - bit 16 set accepts data before first start-of-frame minimum.
// - 4-bit subcarrier detector threshold at bits 15:12.
// - lookup adjustments sign-magnitude, up to three steps, added to fields.
// - 4-bit phase-shift detector threshold at bits 11:8, lookup adjusted.
// - read-only bit 7 shows short correlator evaluation period in use.
// - bits 6:5 collision strength: 12.5, 25 or 50 percent.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "rmdc_defs.vh"

module rmdc_reader_demod_config #(
  parameter SW = 8
) (
  input  wire          clk,
  input  wire          reset,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [11:0]   paddr,
  input  wire [31:0]   pwdata,
  output wire          pready,
  output reg  [31:0]   prdata,
  output reg           pslverr,
  input  wire          rx_reset,
  input  wire          sof_active,
  input  wire          corr_equal,
  input  wire          sof_min,
  input  wire          bpsk_mode,
  input  wire          corr_0110,
  input  wire          corr_1110,
  input  wire          corr_0111,
  input  wire          short_eval_period,
  input  wire          sample_valid,
  input  wire [SW-1:0] i_sample,
  input  wire [SW-1:0] q_sample,
  input  wire          i_detect,
  input  wire          q_detect,
  input  wire          lookup_strobe,
  input  wire [2:0]    lookup_adj_subcarrier,
  input  wire [2:0]    lookup_adj_phase,
  input  wire          coll_valid,
  input  wire [SW-1:0] primary_level,
  input  wire [SW-1:0] secondary_level,
  output reg  [SW-1:0] chan_sample,
  output reg  [1:0]    chan_used,
  output reg           chan_valid,
  output reg           resync_pulse,
  output reg           correlator_clear,
  output reg           bit_corr_valid,
  output reg           data_accept,
  output reg           collision,
  output wire [3:0]    subcarrier_threshold,
  output wire [3:0]    phase_shift_threshold,
  output wire          test_phase_filter
);

  // ***************************************************************
  // register fields
  // ***************************************************************
  reg  [2:0] iq_channel_select;
  reg        test_filt;
  reg        resync_on_equal;
  reg        correlator_clear_on_reset;
  reg        validity_filter_disable;
  reg        data_before_min;
  reg  [3:0] sc_th;
  reg  [3:0] ps_th;
  reg  [1:0] collision_strength;
  reg        ready_q;

  // only one word is mapped; all else is refused
  wire addr_hit = (paddr == `RMDC_CFG_OFFSET);
  wire access   = psel & penable;
  // write takes effect at the edge that samples pready
  wire wr_fire  = access & pready & pwrite & addr_hit;

  assign pready                = ready_q;
  assign subcarrier_threshold  = sc_th;
  assign phase_shift_threshold = ps_th;
  assign test_phase_filter     = test_filt;

  // saturating sign-magnitude add onto a 4-bit threshold
  // a negative step larger than the value clamps at zero
  function [3:0] adj_th;
    input [3:0] cur;
    input [2:0] code;
    reg   [4:0] sum;
    begin
      sum = 5'h00;
      if (code[2]) begin
        if ({3'h0, code[1:0]} > {1'b0, cur})
          adj_th = 4'h0;
        else
          adj_th = cur - {2'h0, code[1:0]};
      end else begin
        sum = {1'b0, cur} + {3'h0, code[1:0]};
        if (sum[4])
          adj_th = 4'hF;
        else
          adj_th = sum[3:0];
      end
    end
  endfunction

  wire [31:0] reg_view = {8'h00,
                          iq_channel_select,
                          test_filt,
                          resync_on_equal,
                          correlator_clear_on_reset,
                          validity_filter_disable,
                          data_before_min,
                          sc_th,
                          ps_th,
                          short_eval_period,
                          collision_strength,
                          5'h00};

  // ***************************************************************
  // apb slave: one wait state, registered read data
  // ***************************************************************
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ready_q <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      // pready rises one cycle after the first access cycle
      // and drops again, so a held access sees it toggle every cycle
      ready_q <= access & ~ready_q;
      if (access & ~ready_q) begin
        // unmapped offsets answer with pslverr and read as zero
        pslverr <= ~addr_hit;
        if (~pwrite & addr_hit)
          prdata <= reg_view;
        else
          prdata <= 32'h00000000;
      end
    end
  end

  // ***************************************************************
  // configuration register
  // ***************************************************************
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      iq_channel_select         <= `RMDC_RST_IQ;
      test_filt                 <= `RMDC_RST_TESTF;
      resync_on_equal           <= `RMDC_RST_RESYNC;
      correlator_clear_on_reset <= `RMDC_RST_CCLR;
      validity_filter_disable   <= `RMDC_RST_VFOFF;
      data_before_min           <= `RMDC_RST_DBMIN;
      sc_th                     <= `RMDC_RST_TH;
      ps_th                     <= `RMDC_RST_TH;
      collision_strength        <= `RMDC_RST_COLL;
    end else if (wr_fire) begin
      iq_channel_select         <= pwdata[`RMDC_IQ_MSB:`RMDC_IQ_LSB];
      test_filt                 <= pwdata[`RMDC_TESTF_BIT];
      resync_on_equal           <= pwdata[`RMDC_RESYNC_BIT];
      correlator_clear_on_reset <= pwdata[`RMDC_CCLR_BIT];
      validity_filter_disable   <= pwdata[`RMDC_VFOFF_BIT];
      data_before_min           <= pwdata[`RMDC_DBMIN_BIT];
      sc_th                     <= pwdata[`RMDC_SCTH_MSB:`RMDC_SCTH_LSB];
      ps_th                     <= pwdata[`RMDC_PSTH_MSB:`RMDC_PSTH_LSB];
      collision_strength        <= pwdata[`RMDC_COLL_MSB:`RMDC_COLL_LSB];
    end else if (lookup_strobe) begin
      // bus write above has priority over a lookup step
      // relative lookup adjustment
      sc_th <= adj_th(sc_th, lookup_adj_subcarrier);
      ps_th <= adj_th(ps_th, lookup_adj_phase);
    end
  end

  // ***************************************************************
  // channel selection
  // ***************************************************************
  reg          first_seen;
  reg          first_is_q;
  // both-channel mode averages; carry kept for the halving
  wire [SW:0]  iq_sum    = {1'b0, i_sample} + {1'b0, q_sample};
  wire         q_bigger  = (q_sample > i_sample);
  reg [SW-1:0] next_sample;
  reg [1:0]    next_used;
  reg          next_valid;

  always @* begin
    next_sample = {SW{1'b0}};
    next_used   = 2'h0;
    next_valid  = sample_valid;
    // mode decode, reserved codes give no sample
    case (iq_channel_select)
      `RMDC_IQ_BOTH: begin
        next_sample = iq_sum[SW:1];
        next_used   = 2'h3;
      end
      `RMDC_IQ_ONLY_I: begin
        next_sample = i_sample;
        next_used   = 2'h1;
      end
      `RMDC_IQ_ONLY_Q: begin
        next_sample = q_sample;
        next_used   = 2'h2;
      end
      `RMDC_IQ_STRONG: begin
        next_sample = q_bigger ? q_sample : i_sample;
        next_used   = q_bigger ? 2'h2 : 2'h1;
      end
      `RMDC_IQ_FIRST: begin
        next_sample = first_is_q ? q_sample : i_sample;
        next_used   = first_is_q ? 2'h2 : 2'h1;
        next_valid  = sample_valid & first_seen;
      end
      default: begin
        next_valid  = 1'b0;
      end
    endcase
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      first_seen  <= 1'b0;
      first_is_q  <= 1'b0;
      chan_sample <= {SW{1'b0}};
      chan_used   <= 2'h0;
      chan_valid  <= 1'b0;
    end else begin
      chan_sample <= next_sample;
      chan_used   <= next_used;
      chan_valid  <= next_valid;
      // detect with rx_reset in one cycle relatches: set wins
      if ((i_detect | q_detect) & (~first_seen | rx_reset)) begin
        // first channel latched, I wins a tie
        first_seen <= 1'b1;
        first_is_q <= ~i_detect;
      end else if (rx_reset) begin
        first_seen <= 1'b0;
        first_is_q <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // frame control and correlation outputs
  // ***************************************************************
  reg        min_seen;
  // fraction of the primary level per collision code
  wire [SW-1:0] coll_ref =
    (collision_strength == `RMDC_COLL_P12) ? (primary_level >> 3) :
    (collision_strength == `RMDC_COLL_P25) ? (primary_level >> 2) :
    (primary_level >> 1);

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      min_seen         <= 1'b0;
      resync_pulse     <= 1'b0;
      correlator_clear <= 1'b0;
      bit_corr_valid   <= 1'b0;
      data_accept      <= 1'b0;
      collision        <= 1'b0;
    end else begin
      // minimum and rx_reset in one cycle: the minimum is kept
      if (sof_min)
        min_seen <= 1'b1;
      else if (rx_reset)
        min_seen <= 1'b0;
      data_accept      <= data_before_min | sof_min | (min_seen & ~rx_reset);
      resync_pulse     <= resync_on_equal & sof_active & corr_equal;
      correlator_clear <= correlator_clear_on_reset & rx_reset;
      if (bpsk_mode & ~validity_filter_disable)
        bit_corr_valid <= corr_0110 & (corr_1110 | corr_0111);
      else
        bit_corr_valid <= corr_0110;
      if (collision_strength == `RMDC_COLL_OFF)
        collision <= 1'b0;
      else
        collision <= coll_valid & (secondary_level > coll_ref);
    end
  end

endmodule // rmdc_reader_demod_config

`default_nettype wire

// File: dv/rmdc_card_model.sv
// rmdc_card_model.sv: far-side card signal as I/Q samples and detect flags.
// assumes clk is the core clock; frame_on marks a received frame.
`timescale 1ns/100ps
`default_nettype none
module rmdc_card_model (
  input  wire logic       clk,
  input  wire logic       frame_on,
  input  wire logic [7:0] amp_i,
  input  wire logic [7:0] amp_q,
  output logic            sample_valid,
  output logic [7:0]      i_sample,
  output logic [7:0]      q_sample,
  output logic            i_detect,
  output logic            q_detect
);
  logic [7:0] junk = 8'h00;
  always @(posedge clk) begin
    junk <= junk + 8'h5B;
    sample_valid <= frame_on;
    // outside a frame the lines carry changing junk
    i_sample <= frame_on ? amp_i : junk;
    q_sample <= frame_on ? amp_q : ~junk;
    i_detect <= frame_on && amp_i != 8'h00;
    q_detect <= frame_on && amp_q != 8'h00;
  end
endmodule // rmdc_card_model
`default_nettype wire

// File: dv/rmdc_monitor.sv
// rmdc_monitor.sv: port assertions of the demod config block.
// assumes one clock domain and the async high reset.
`timescale 1ns/100ps
`default_nettype none
module rmdc_monitor #(parameter SW = 8) (
  input wire logic          clk,
  input wire logic          reset,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic [11:0]   paddr,
  input wire logic [31:0]   pwdata,
  input wire logic          rx_reset,
  input wire logic          sof_active,
  input wire logic          corr_equal,
  input wire logic          bpsk_mode,
  input wire logic          corr_0110,
  input wire logic          corr_1110,
  input wire logic          corr_0111,
  input wire logic          coll_valid,
  input wire logic          resync_pulse,
  input wire logic          correlator_clear,
  input wire logic          bit_corr_valid,
  input wire logic          data_accept,
  input wire logic          collision,
  input wire logic [SW-1:0] primary_level,
  input wire logic [SW-1:0] secondary_level
);
  logic [31:0] sh;
  // shadow of the writable fields
  always_ff @(posedge clk or posedge reset)
    if (reset) sh <= 32'h000C0000;
    else if (psel && penable && pready && pwrite && paddr == 12'h01C) sh <= pwdata;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  apb_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("apb answer timing");
  apb_err_a: assert property (psel && penable && pready |-> pslverr == (paddr != 12'h01C))
    else $error("apb error flag");
  resync_equal_a: assert property (sof_active && corr_equal |=> resync_pulse == $past(sh[19]))
    else $error("resync pulse");
  corr_clear_a: assert property (rx_reset && sh[18] |=> correlator_clear)
    else $error("correlator clear");
  valid_filter_a: assert property (bpsk_mode && !sh[17] && corr_0110 && !corr_1110 && !corr_0111 |=>
    !bit_corr_valid)
    else $error("validity filter");
  early_data_a: assert property (sh[16] |=> data_accept)
    else $error("early data");
  coll_half_a: assert property (coll_valid && sh[6:5] == 2'h2 && secondary_level > (primary_level >> 1) |=>
    collision)
    else $error("collision level");
  coll_off_a: assert property (sh[6:5] == 2'h3 |=> !collision)
    else $error("collision off");
endmodule // rmdc_monitor
bind rmdc_reader_demod_config rmdc_monitor #(.SW(SW)) u_rmdc_monitor (
  .clk              (clk),
  .reset            (reset),
  .psel             (psel),
  .penable          (penable),
  .pwrite           (pwrite),
  .pready           (pready),
  .pslverr          (pslverr),
  .paddr            (paddr),
  .pwdata           (pwdata),
  .rx_reset         (rx_reset),
  .sof_active       (sof_active),
  .corr_equal       (corr_equal),
  .bpsk_mode        (bpsk_mode),
  .corr_0110        (corr_0110),
  .corr_1110        (corr_1110),
  .corr_0111        (corr_0111),
  .coll_valid       (coll_valid),
  .resync_pulse     (resync_pulse),
  .correlator_clear (correlator_clear),
  .bit_corr_valid   (bit_corr_valid),
  .data_accept      (data_accept),
  .collision        (collision),
  .primary_level    (primary_level),
  .secondary_level  (secondary_level)
);
`default_nettype wire

// File: dv/rmdc_reader_demod_config_tb_top.sv
// rmdc_reader_demod_config_tb_top.sv: directed bench of the demod config block.
// assumes the card model feeds samples; other inputs come from here.
`timescale 1ns/100ps
`default_nettype none
module rmdc_reader_demod_config_tb_top;
  logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e, frame_on = 1'b0;
  logic rx_reset = 1'b0, sof_active = 1'b0, corr_equal = 1'b0, sof_min = 1'b0, bpsk_mode = 1'b0;
  logic corr_0110 = 1'b0, corr_1110 = 1'b0, corr_0111 = 1'b0, short_eval_period = 1'b0;
  logic lookup_strobe = 1'b0, coll_valid = 1'b0, pready, pslverr, chan_valid, resync_pulse;
  logic correlator_clear, bit_corr_valid, data_accept, collision, test_phase_filter;
  logic sample_valid, i_detect, q_detect;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, r, prdata;
  logic [2:0]  lookup_adj_subcarrier = 3'h0, lookup_adj_phase = 3'h0;
  logic [7:0]  primary_level = 8'h00, secondary_level = 8'h00, amp_i = 8'h00, amp_q = 8'h00;
  logic [7:0]  i_sample, q_sample, chan_sample;
  logic [3:0]  subcarrier_threshold, phase_shift_threshold;
  logic [1:0]  chan_used;
  int fail_count = 0, comparisons = 0;
  rmdc_reader_demod_config u_rmdc_reader_demod_config (.*);
  rmdc_card_model u_rmdc_card_model (.*);
  always #5 clk = ~clk;
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      fail_count++;
      $display("unexpected %s exp %h got %h", s, x, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one transfer, then one idle cycle
  task automatic apb(input logic w, input logic [31:0] d, input logic [11:0] a = 12'h01C);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    tick(1);
    penable <= 1'b1;
    do begin
      tick(1);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      chk("pready", 1, pready);
      end_sim();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    tick(1);
  endtask
  task automatic t_regs;
    apb(0, 0);
    chk("reset value", 32'h000C0000, r);
    short_eval_period <= 1'b1;
    apb(1, 32'h00EFFFFF);
    apb(0, 0);
    chk("readback", 32'h00EFFFE0, r);
    chk("test filter", 0, test_phase_filter);
    apb(1, 0, 12'h020);
    chk("unmapped err", 1, e);
    apb(0, 0);
    chk("unmapped write", 32'h00EFFFE0, r);
  endtask
  task automatic t_iq;
    logic [2:0] cd[6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h3};
    logic [7:0] es[6] = '{8'h30, 8'h40, 8'h20, 8'h40, 8'h40, 8'h00};
    logic [1:0] eu[6] = '{2'h3, 2'h1, 2'h2, 2'h1, 2'h1, 2'h0};
    amp_i <= 8'h40;
    amp_q <= 8'h20;
    frame_on <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      apb(1, {8'h00, cd[k], 21'h0});
      tick(3);
      chk("chan sample", es[k], chan_sample);
      chk("chan used", eu[k], chan_used);
      chk("chan valid", cd[k] != 3'h3, chan_valid);
    end
    // q detected first after rx_reset stays chosen when I grows
    apb(1, {8'h00, 3'h5, 21'h0});
    rx_reset <= 1'b1;
    amp_i <= 8'h00;
    tick(2);
    rx_reset <= 1'b0;
    amp_i <= 8'h60;
    tick(3);
    chk("first chan", 8'h20, chan_sample);
    chk("first used", 2'h2, chan_used);
  endtask
  task automatic t_coll;
    logic [7:0] sec[2] = '{8'h20, 8'h41};
    logic [3:0] hit[2] = '{4'b0001, 4'b0111};
    primary_level <= 8'h80;
    coll_valid <= 1'b1;
    for (int s = 0; s < 2; s++)
      for (int c = 0; c < 4; c++) begin
        secondary_level <= sec[s];
        apb(1, {25'h0, c[1:0], 5'h0});
        tick(2);
        chk("collision", hit[s][c], collision);
      end
  endtask
  task automatic ctl(input logic [3:0] x);
    tick(2);
    chk("ctl outputs", x, {resync_pulse, correlator_clear, bit_corr_valid, data_accept});
  endtask
  task automatic t_ctrl;
    apb(1, 0);
    bpsk_mode <= 1'b1;
    corr_0110 <= 1'b1;
    sof_active <= 1'b1;
    corr_equal <= 1'b1;
    rx_reset <= 1'b1;
    ctl(4'b0000);
    rx_reset <= 1'b0;
    corr_1110 <= 1'b1;
    sof_min <= 1'b1;
    tick(1);
    sof_min <= 1'b0;
    ctl(4'b0011);
    corr_1110 <= 1'b0;
    rx_reset <= 1'b1;
    apb(1, 32'h000F0000);
    ctl(4'b1111);
    rx_reset <= 1'b0;
  endtask
  task automatic lookup_step(input logic [2:0] s, input logic [2:0] p);
    lookup_adj_subcarrier <= s;
    lookup_adj_phase <= p;
    lookup_strobe <= 1'b1;
    tick(1);
    lookup_strobe <= 1'b0;
    tick(2);
  endtask
  task automatic t_lookup;
    apb(1, 32'h00002E00);
    lookup_step(3'b111, 3'b011);
    chk("sub thresh", 4'h0, subcarrier_threshold);
    chk("phase thresh", 4'hF, phase_shift_threshold);
    lookup_step(3'b001, 3'b110);
    apb(0, 0);
    chk("adjusted", 32'h00001D80, r);
  endtask
  initial begin
    tick(8);
    reset <= 1'b0;
    tick(1);
    t_regs();
    t_iq();
    t_coll();
    t_ctrl();
    t_lookup();
    end_sim();
  end
endmodule // rmdc_reader_demod_config_tb_top
`default_nettype wire
